// ### hdl/vfc_pkg.sv
// Purpose: Shared constants and carriers for the video filter control bank.
// Assumes: AXI4-Lite byte addresses; every register is one aligned word.
// Notes:   Operation summary follows.
// Operation
// - Slave port has 32-bit addresses and 32-bit data on all channels.
// - Write response and read data each return a 2-bit response code.
// - Inputs sampled on rising control clock edge; stream side independent.
// - Clock enable low freezes bus handshakes and register writes; core events still update flags, counters and active set.
// - Low control reset acts on the next edge even with enable low.
// - Control reset is resynchronized into the video clock domain.
// - Control resets to zero: enable, commit, bypass, pattern, reset bits.
// - Soft enable low halts the core; it defaults to zero.
// - Soft enable changes act at once, not at a frame boundary.
// - Frame size and filter strengths have host and active copies.
// - At frame end, host copies go active only if commit is set.
// - With debug built in, bypass copies input samples to output.
// - With debug built in, test pattern bit selects pattern generation.
// - Three read-only counters of frames, lines, pixels; reset to zero.
// - The counters exist only when debug features are built in.
// - Frame size register resets to the build-time frame size.
// - Noise limit holds values zero to two to the sample width minus one.
// - Edge gain and halo damping are 16-bit values with 15 fraction bits.
// - Interrupt mask holds one enable per event flag, bits 16 to 0.
// - Event and fault flags stay set until a one is written to clear.
// - Interrupt is the OR of each event flag ANDed with its mask bit.
// - Frame size holds pixels per line in 12:0, lines in 28:16.
// - Frame-synced reset fires at frame end or when idle; then clears.
package vfc_pkg;

  localparam logic [31:0] OFS_CONTROL  = 32'h0000_0000;
  localparam logic [31:0] OFS_EVENTS   = 32'h0000_0004;
  localparam logic [31:0] OFS_FAULTS   = 32'h0000_0008;
  localparam logic [31:0] OFS_IRQ_MASK = 32'h0000_000c;
  localparam logic [31:0] OFS_BUILD_ID = 32'h0000_0010;
  localparam logic [31:0] OFS_FRAMES   = 32'h0000_0014;
  localparam logic [31:0] OFS_LINES    = 32'h0000_0018;
  localparam logic [31:0] OFS_PIXELS   = 32'h0000_001c;
  localparam logic [31:0] OFS_DIMS     = 32'h0000_0020;
  localparam logic [31:0] OFS_NOISE    = 32'h0000_0100;
  localparam logic [31:0] OFS_GAIN     = 32'h0000_0104;
  localparam logic [31:0] OFS_HALO     = 32'h0000_0108;

  localparam int CTL_EN_BIT     = 0;
  localparam int CTL_COMMIT_BIT = 1;
  localparam int CTL_BYPASS_BIT = 4;
  localparam int CTL_TPAT_BIT   = 5;
  localparam int CTL_FSYNC_BIT  = 30;
  localparam int CTL_SRST_BIT   = 31;
  localparam int EVT_BEGUN_BIT  = 0;
  localparam int EVT_EOF_BIT    = 1;
  localparam int EVT_FAULT_BIT  = 16;
  localparam int DIM_COLS_LSB   = 0;
  localparam int DIM_ROWS_LSB   = 16;
  localparam int DIM_W          = 13;
  localparam int MASK_W         = 17;
  localparam int FAULT_W        = 4;

  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [31:0] CTL_RESET  = 32'h0000_0000;
  localparam logic [31:0] CNT_RESET  = 32'h0000_0000;

  typedef struct packed {
    logic [DIM_W-1:0] rows;
    logic [DIM_W-1:0] cols;
    logic [15:0]      noise;
    logic [15:0]      gain;
    logic [15:0]      halo;
  } filt_set_t;

  typedef struct packed {
    logic              bvalid;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [31:0]       ctl;
    logic [MASK_W-1:0] evt;
    logic [FAULT_W-1:0] fault;
    logic [MASK_W-1:0] mask;
    logic [31:0]       frames;
    logic [31:0]       lines;
    logic [31:0]       pixels;
    filt_set_t         host;
    filt_set_t         act;
    logic              fsync_pls;
  } ctl_state_t;

endpackage

// ### hdl/video_filter_control_regs.sv
// Purpose: AXI4-Lite register bank steering a video enhancement core.
// Assumes: Core event pulses arrive in the clk_sys domain.
// Notes:   Only the reset synchronizer runs on the video clock.
`timescale 1ns/1ps
module video_filter_control_regs
  import vfc_pkg::*;
#(
  parameter bit          DEBUG_EN  = 1'b1,
  parameter int          SAMPLE_W  = 8,
  parameter logic [12:0] DEF_COLS  = 13'h0780,
  parameter logic [12:0] DEF_ROWS  = 13'h0438,
  parameter logic [15:0] DEF_NOISE = 16'h0010,
  parameter logic [15:0] DEF_GAIN  = 16'h4000,
  parameter logic [15:0] DEF_HALO  = 16'h4000,
  // Arbitrary neutral build identifier.
  parameter logic [31:0] BUILD_ID  = 32'h0102_0300
) (
  // Control clock, enable and reset
  input  wire logic        clk_sys,
  input  wire logic        aclken,
  input  wire logic        srst_n,
  // Video clock and its reset
  input  wire logic        vid_clk,
  output logic             vid_rst_n,
  // AXI4-Lite write channels
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Core events
  input  wire logic        frame_start_evt,
  input  wire logic        frame_end_evt,
  input  wire logic        line_end_evt,
  input  wire logic        pixel_evt,
  input  wire logic [3:0]  fault_evt,
  input  wire logic        core_idle,
  // Core controls
  output logic             core_run,
  output logic             core_bypass,
  output logic             core_test_pattern,
  output logic             core_soft_reset,
  output logic             core_frame_reset,
  output filt_set_t        active_set,
  output logic             irq
);

  localparam logic [15:0] NOISE_MASK =
    16'((32'h1 << SAMPLE_W) - 32'h1);
  localparam filt_set_t SET_RESET = '{rows: DEF_ROWS, cols: DEF_COLS,
    noise: DEF_NOISE & NOISE_MASK, gain: DEF_GAIN, halo: DEF_HALO};

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  logic       wr_go;
  logic       rd_go;
  logic       vrst_s0_r;
  logic       vrst_s1_r;

  // Both write channels are taken together, so a lone address waits for its
  // data, and neither is taken while a response is pending.
  assign s_axi_awready = aclken && s_axi_awvalid && s_axi_wvalid &&
                         !st_r.bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = aclken && !st_r.rvalid;
  assign wr_go = s_axi_awready;
  assign rd_go = aclken && s_axi_arvalid && s_axi_arready;

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata  = st_r.rdata;
  assign s_axi_bresp  = RESP_OKAY;
  assign s_axi_rresp  = RESP_OKAY;

  assign core_run          = st_r.ctl[CTL_EN_BIT];
  assign core_bypass       = DEBUG_EN && st_r.ctl[CTL_BYPASS_BIT];
  assign core_test_pattern = DEBUG_EN && st_r.ctl[CTL_TPAT_BIT];
  assign core_soft_reset   = st_r.ctl[CTL_SRST_BIT];
  assign core_frame_reset  = st_r.fsync_pls;
  assign active_set        = st_r.act;
  assign irq = |(st_r.evt & st_r.mask);

  always_comb begin
    logic [MASK_W-1:0]  evt_set;
    logic [MASK_W-1:0]  evt_clr;
    logic [FAULT_W-1:0] flt_clr;
    logic               cnt_clr;
    st_nxt  = st_r;
    evt_set = '0;
    evt_clr = '0;
    flt_clr = '0;
    cnt_clr = st_r.ctl[CTL_SRST_BIT] || st_r.fsync_pls;

    // Bus side only moves while the clock enable is high.
    if (aclken) begin
      if (st_r.bvalid && s_axi_bready) begin
        st_nxt.bvalid = 1'b0;
      end
      if (st_r.rvalid && s_axi_rready) begin
        st_nxt.rvalid = 1'b0;
      end
      if (wr_go) begin
        st_nxt.bvalid = 1'b1;
        case (s_axi_awaddr)
          OFS_CONTROL:  st_nxt.ctl = s_axi_wdata &
                          32'hc000_0033;
          OFS_EVENTS:   evt_clr = s_axi_wdata[MASK_W-1:0];
          OFS_FAULTS:   flt_clr = s_axi_wdata[FAULT_W-1:0];
          OFS_IRQ_MASK: st_nxt.mask = s_axi_wdata[MASK_W-1:0];
          OFS_DIMS: begin
            st_nxt.host.cols = s_axi_wdata[DIM_COLS_LSB +: DIM_W];
            st_nxt.host.rows = s_axi_wdata[DIM_ROWS_LSB +: DIM_W];
          end
          OFS_NOISE: st_nxt.host.noise =
                       s_axi_wdata[15:0] & NOISE_MASK;
          OFS_GAIN:  st_nxt.host.gain = s_axi_wdata[15:0];
          OFS_HALO:  st_nxt.host.halo = s_axi_wdata[15:0];
          default:   st_nxt.bvalid = 1'b1;
        endcase
      end
      if (rd_go) begin
        st_nxt.rvalid = 1'b1;
        case (s_axi_araddr)
          OFS_CONTROL:  st_nxt.rdata = st_r.ctl;
          OFS_EVENTS:   st_nxt.rdata = 32'(st_r.evt);
          OFS_FAULTS:   st_nxt.rdata = 32'(st_r.fault);
          OFS_IRQ_MASK: st_nxt.rdata = 32'(st_r.mask);
          OFS_BUILD_ID: st_nxt.rdata = BUILD_ID;
          OFS_FRAMES:   st_nxt.rdata = st_r.frames;
          OFS_LINES:    st_nxt.rdata = st_r.lines;
          OFS_PIXELS:   st_nxt.rdata = st_r.pixels;
          OFS_DIMS:     st_nxt.rdata = {3'h0, st_r.host.rows,
                                        3'h0, st_r.host.cols};
          OFS_NOISE:    st_nxt.rdata = {16'h0, st_r.host.noise};
          OFS_GAIN:     st_nxt.rdata = {16'h0, st_r.host.gain};
          OFS_HALO:     st_nxt.rdata = {16'h0, st_r.host.halo};
          default:      st_nxt.rdata = 32'h0;
        endcase
      end
    end

    // Core side runs regardless of the bus clock enable so that no event is
    // lost while the bus is frozen.
    evt_set[EVT_BEGUN_BIT] = frame_start_evt;
    evt_set[EVT_EOF_BIT]   = frame_end_evt;
    evt_set[EVT_FAULT_BIT] = |fault_evt;
    st_nxt.evt   = (st_r.evt & ~evt_clr) | evt_set;
    st_nxt.fault = (st_r.fault & ~flt_clr) | fault_evt;

    if (frame_end_evt && st_r.ctl[CTL_COMMIT_BIT]) begin
      st_nxt.act = st_nxt.host;
    end

    // A frame-synced reset fires once and then clears its own request.
    st_nxt.fsync_pls = 1'b0;
    if (st_r.ctl[CTL_FSYNC_BIT] && (frame_end_evt || core_idle)) begin
      st_nxt.fsync_pls           = 1'b1;
      st_nxt.ctl[CTL_FSYNC_BIT]  = 1'b0;
    end

    if (!DEBUG_EN || cnt_clr) begin
      st_nxt.frames = CNT_RESET;
      st_nxt.lines  = CNT_RESET;
      st_nxt.pixels = CNT_RESET;
    end else begin
      st_nxt.frames = st_r.frames + 32'(frame_end_evt);
      st_nxt.lines  = st_r.lines + 32'(line_end_evt);
      st_nxt.pixels = st_r.pixels + 32'(pixel_evt);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!srst_n) begin
      st_r <= '{bvalid: 1'b0, rvalid: 1'b0, rdata: 32'h0,
                ctl: CTL_RESET, evt: '0, fault: '0, mask: '0,
                frames: CNT_RESET, lines: CNT_RESET, pixels: CNT_RESET,
                host: SET_RESET, act: SET_RESET,
                fsync_pls: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Two-stage level crossing; the video side leaves reset two video edges
  // after the control reset is released.
  always_ff @(posedge vid_clk) begin
    vrst_s0_r <= srst_n;
    vrst_s1_r <= vrst_s0_r;
  end
  assign vid_rst_n = vrst_s1_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!srst_n);

  sequence s_write_taken;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence

  sequence s_resp_pending;
    s_axi_bvalid && !s_axi_awready;
  endsequence

  property p_write_resp;
    s_write_taken |=> s_resp_pending;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write taken without a pending response");

  property p_one_write;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_one_write: assert property (p_one_write)
    else $error("second write accepted while response pending");

  property p_read_resp;
    (s_axi_arvalid && s_axi_arready) |=>
      s_axi_rvalid && s_axi_rresp == RESP_OKAY && !s_axi_arready;
  endproperty
  a_read_resp: assert property (p_read_resp)
    else $error("read not answered with OKAY next cycle");

  property p_unmapped_read;
    (rd_go && s_axi_araddr == 32'h0000_0200) |=> s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned nonzero data");

  property p_frozen;
    !aclken |=> $stable(s_axi_bvalid) && $stable(s_axi_rvalid) &&
                $stable(s_axi_rdata) && $stable(st_r.ctl[5:0]);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("bus state moved while clock enable low");

  property p_commit;
    (frame_end_evt && st_r.ctl[CTL_COMMIT_BIT] && !wr_go) |=>
      active_set == $past(st_r.host);
  endproperty
  a_commit: assert property (p_commit)
    else $error("active set not loaded at committed frame end");

  property p_no_commit;
    !(frame_end_evt && st_r.ctl[CTL_COMMIT_BIT]) |=> $stable(active_set);
  endproperty
  a_no_commit: assert property (p_no_commit)
    else $error("active set changed without commit at frame end");

  property p_flag_sticky;
    frame_start_evt ##1 !(wr_go && s_axi_awaddr == OFS_EVENTS)
      |-> st_r.evt[EVT_BEGUN_BIT] ##1 st_r.evt[EVT_BEGUN_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("event flag did not stay set");

  property p_irq;
    (|fault_evt && st_r.mask[EVT_FAULT_BIT] && !wr_go) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled event did not raise the interrupt");

  sequence s_fsync_fire;
    core_frame_reset && !st_r.ctl[CTL_FSYNC_BIT] ##1 !core_frame_reset;
  endsequence

  property p_fsync;
    (st_r.ctl[CTL_FSYNC_BIT] && core_idle && !wr_go) |=> s_fsync_fire;
  endproperty
  a_fsync: assert property (p_fsync)
    else $error("frame-synced reset did not fire and clear");

  property p_reset;
    @(posedge clk_sys) disable iff (1'b0)
      !srst_n |=> st_r.ctl == CTL_RESET && !core_run && !s_axi_bvalid;
  endproperty
  a_reset: assert property (p_reset)
    else $error("control state not cleared by reset");

endmodule

// ### testbench/axil_host_model.sv
// Purpose: AXI4-Lite master model for the control port.
// Assumes: Each task is entered 1 ns after a rising edge of clk_sys.
// Notes:   Released address and data lines carry the inverse value.
`timescale 1ns/1ps
module axil_host_model (
  // Clock and enable
  input  wire logic        clk_sys,
  input  wire logic        aclken,
  // Write channels
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [31:0]      s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
  end

  // Ready is judged just before the edge, so the edge takes it for sure.
  // A ready that never comes is left to the bench watchdog to catch.
  task automatic sync(input int ch);
    logic ok;
    do begin
      @(negedge clk_sys);
      ok = (ch == 0) ? s_axi_awready && s_axi_wready :
           (ch == 1) ? s_axi_bvalid :
           (ch == 2) ? s_axi_arready : s_axi_rvalid;
    end while (!(aclken && ok));
    @(posedge clk_sys);
    #1;
  endtask

  task automatic write(input logic [31:0] a, input logic [31:0] d,
                       input int slow);
    s_axi_awaddr = a;
    s_axi_wdata = d;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    sync(0);
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_awaddr = ~a;
    s_axi_wdata = ~d;
    #(4 * slow);
    s_axi_bready = 1'b1;
    sync(1);
    s_axi_bready = 1'b0;
  endtask

  task automatic read(input logic [31:0] a, input int slow);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    sync(2);
    s_axi_arvalid = 1'b0;
    s_axi_araddr = ~a;
    #(4 * slow);
    s_axi_rready = 1'b1;
    sync(3);
    s_axi_rready = 1'b0;
  endtask
endmodule

// ### testbench/video_filter_control_regs_tb.sv
// Purpose: Self-checking bench for the video filter control bank.
// Assumes: Core events are driven as clk_sys pulses by the bench.
// Notes:   Read data is checked by a monitor against queued notes.
`timescale 1ns/1ps
module video_filter_control_regs_tb;
  import vfc_pkg::*;
  // Arbitrary neutral build identifier.
  localparam logic [31:0] ID = 32'h0a0b_0c0d;
  logic        clk_sys, aclken, srst_n, vid_clk, vid_rst_n, core_idle;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq, core_run, core_bypass;
  logic        frame_start_evt, frame_end_evt, line_end_evt, pixel_evt;
  logic        core_test_pattern, core_soft_reset, core_frame_reset;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  fault_evt;
  logic [7:0]  ev;
  filt_set_t   active_set;
  logic [31:0] exp_q[$], adr_q[$], d[4];
  logic [73:0] dflt, want;
  int          errors, cmp_count, fr_cnt, n, m;
  localparam logic [31:0] A[13] = '{OFS_CONTROL, OFS_EVENTS, OFS_FAULTS,
    OFS_IRQ_MASK, OFS_BUILD_ID, OFS_FRAMES, OFS_LINES, OFS_PIXELS, OFS_DIMS,
    OFS_NOISE, OFS_GAIN, OFS_HALO, 32'h0000_0200};
  localparam logic [31:0] R[13] = '{CTL_RESET, 32'h0, 32'h0, 32'h0, ID,
    CNT_RESET, CNT_RESET, CNT_RESET, 32'h0438_0780, 32'h0000_0010,
    32'h0000_4000, 32'h0000_4000, 32'h0};

  assign {fault_evt, pixel_evt, line_end_evt, frame_end_evt,
          frame_start_evt} = ev;

  video_filter_control_regs #(.BUILD_ID(ID), .DEF_COLS(13'h0780),
    .DEF_ROWS(13'h0438), .DEF_NOISE(16'h0010), .DEF_GAIN(16'h4000),
    .DEF_HALO(16'h4000)) video_filter_control_regs_i (.*);
  axil_host_model axil_host_model_i (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    vid_clk = 1'b0;
    forever #3.5 vid_clk = ~vid_clk;
  end

  task automatic chk(string nm, logic [79:0] e, logic [79:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    axil_host_model_i.write(a, v, $urandom_range(3));
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input int slow = -1);
    exp_q.push_back(e);
    adr_q.push_back(a);
    axil_host_model_i.read(a, slow < 0 ? $urandom_range(3) : slow);
  endtask

  // Two cycles per pulse keep back-to-back pulses apart.
  task automatic pls(input logic [7:0] v);
    ev = v;
    @(posedge clk_sys);
    #1 ev = 8'h00;
    @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys) begin
    fr_cnt <= fr_cnt + int'(core_frame_reset === 1'b1);
    if (aclken && s_axi_rvalid && s_axi_rready) begin
      chk($sformatf("rdata at %h", adr_q.pop_front()), exp_q.pop_front(),
          s_axi_rdata);
      chk("rresp", RESP_OKAY, s_axi_rresp);
    end
    if (aclken && s_axi_bvalid && s_axi_bready)
      chk("bresp", RESP_OKAY, s_axi_bresp);
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    complete_run();
  end

  initial begin
    void'($urandom(32'he716ec59));
    {errors, cmp_count, fr_cnt} = '0;
    {aclken, srst_n, core_idle, ev} = {3'h4, 8'h00};
    repeat (12) @(posedge clk_sys);
    #1 srst_n = 1'b1;
    for (int i = 0; i < 13; i++)
      rd(A[i], R[i]);
    n = $urandom_range(1, 5);
    m = $urandom_range(1, 5);
    repeat (n) pls(8'h0e);
    repeat (m) pls(8'h08);
    rd(OFS_FRAMES, 32'(n));
    rd(OFS_LINES, 32'(n));
    rd(OFS_PIXELS, 32'(n + m));
    dflt = {13'h0438, 13'h0780, 16'h0010, 16'h4000, 16'h4000};
    d[0] = {16'($urandom_range(32, 7680)), 16'($urandom_range(32, 7680))};
    d[1] = $urandom_range(255);
    d[2] = $urandom_range(32768);
    d[3] = $urandom_range(32768);
    wr(OFS_CONTROL, 32'h0);
    for (int i = 0; i < 4; i++)
      wr(A[i + 8], d[i]);
    for (int i = 0; i < 4; i++)
      rd(A[i + 8], d[i]);
    pls(8'h02);
    chk("active_set", dflt, active_set);
    wr(OFS_CONTROL, 32'h2);
    chk("active_set", dflt, active_set);
    pls(8'h02);
    want = {d[0][28:16], d[0][12:0], d[1][15:0], d[2][15:0], d[3][15:0]};
    chk("active_set", want, active_set);
    wr(OFS_CONTROL, 32'hffff_ffff);
    chk("ctl outs", 4'hf, {core_run, core_bypass, core_test_pattern,
        core_soft_reset});
    rd(OFS_CONTROL, 32'hc000_0033);
    pls(8'h02);
    rd(OFS_CONTROL, 32'h8000_0033);
    core_idle = 1'b1;
    wr(OFS_CONTROL, 32'h4000_0001);
    rd(OFS_CONTROL, 32'h0000_0001);
    core_idle = 1'b0;
    chk("frame resets", 2, fr_cnt);
    wr(OFS_CONTROL, 32'h0);
    chk("core_run", 0, core_run);
    wr(OFS_IRQ_MASK, 32'hffff_ffff);
    rd(OFS_IRQ_MASK, 32'h0001_ffff);
    wr(OFS_IRQ_MASK, 32'h0001_0000);
    wr(OFS_EVENTS, 32'hffff_ffff);
    wr(OFS_FAULTS, 32'hffff_ffff);
    rd(OFS_EVENTS, 32'h0);
    pls(8'h11);
    rd(OFS_EVENTS, 32'h0001_0001);
    chk("irq", 1, irq);
    wr(OFS_EVENTS, 32'h1);
    rd(OFS_EVENTS, 32'h0001_0000);
    wr(OFS_EVENTS, 32'h0001_0000);
    chk("irq", 0, irq);
    wr(OFS_FAULTS, 32'h1);
    for (int k = 0; k < 4; k++) begin
      pls(8'h10 << k);
      rd(OFS_FAULTS, 32'h1 << k);
      wr(OFS_FAULTS, 32'h1 << k);
    end
    chk("irq", 1, irq);
    wr(OFS_IRQ_MASK, 32'h0);
    chk("irq", 0, irq);
    fork
      rd(OFS_IRQ_MASK, 32'h0, 8);
      begin
        repeat (2) @(posedge clk_sys);
        #1 aclken = 1'b0;
        repeat (9) @(posedge clk_sys);
        chk("rvalid", 1, s_axi_rvalid);
        #1 aclken = 1'b1;
      end
    join
    wr(32'h0000_0044, $urandom);
    rd(32'h0000_0044, 32'h0);
    wr(OFS_BUILD_ID, 32'h0);
    rd(OFS_BUILD_ID, ID);
    wr(OFS_CONTROL, 32'h1);
    {aclken, srst_n} = 2'h0;
    // Held past 32 periods of the slower video clock.
    repeat (60) @(posedge clk_sys);
    #1 chk("vid_rst_n", 0, vid_rst_n);
    chk("core_run", 0, core_run);
    {aclken, srst_n} = 2'h3;
    repeat (6) @(posedge vid_clk);
    chk("vid_rst_n", 1, vid_rst_n);
    @(posedge clk_sys);
    #1 rd(OFS_CONTROL, 32'h0);
    chk("reads left", 0, exp_q.size());
    complete_run();
  end
endmodule
